// ===== dv/pcs_core_sva.sv
`timescale 1ns/1ps
module pcs_core_sva
(
  input wire logic             clk,
  input wire logic             rstn,
  input wire pcs_pkg::pcs_op_t op,
  input wire logic [20:0]      target,
  input wire logic             boot_partition_enable_n,
  input wire logic             storage_partition_enable_n,
  input wire logic             app_region_write_protect,
  input wire logic             stack_fault_reset_enable,
  input wire logic             nvm_write_req,
  input wire logic [20:0]      nvm_write_addr,
  input wire logic [3:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  input wire logic [20:0]      pc,
  input wire logic             fetch_exec_ok,
  input wire logic             nvm_write_go,
  input wire logic             stack_fault_reset
);
  localparam logic [20:0] SB = pcs_pkg::FLASH_LAST - pcs_pkg::SAF_SPAN;
  logic [7:0] pc_low_byte;
  assign pc_low_byte = pc[7:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  pc_even_a: assert property (pc[0] == 1'b0)
    else $error("pc odd");
  seq_step_a: assert property (
    op == pcs_pkg::PCS_OP_SEQ && !reg_wr |=> pc == $past(pc) + 21'h000002)
    else $error("sequential step wrong");
  jump_load_a: assert property (
    op == pcs_pkg::PCS_OP_JUMP && !reg_wr
    |=> pc == ($past(target) & 21'h1FFFFE)) else $error("jump target wrong");
  call_load_a: assert property (
    op == pcs_pkg::PCS_OP_CALL && !reg_wr && !stack_fault_reset_enable
    |=> pc == ($past(target) & 21'h1FFFFE)) else $error("call target wrong");
  fault_cause_a: assert property (
    stack_fault_reset |-> pc == 21'h000000 && $past(stack_fault_reset_enable)
    && $past(op) inside {pcs_pkg::PCS_OP_CALL, pcs_pkg::PCS_OP_RET})
    else $error("stray fault reset");
  low_read_a: assert property (
    reg_rd && reg_addr == pcs_pkg::A_PCL |=> reg_rdata == $past(pc_low_byte))
    else $error("low byte read wrong");
  low_write_a: assert property (
    reg_wr && reg_addr == pcs_pkg::A_PCL |=> pc_low_byte == ($past(reg_wdata) & 8'hFE))
    else $error("low byte write wrong");
  saf_noexec_a: assert property (
    !storage_partition_enable_n && $stable(storage_partition_enable_n)
    && $stable(pc) && pc >= SB - 21'h000002
    && pc <= pcs_pkg::FLASH_LAST - 21'h000002 |-> !fetch_exec_ok)
    else $error("storage fetch allowed");
  app_prot_a: assert property (
    nvm_write_req && boot_partition_enable_n && storage_partition_enable_n
    && nvm_write_addr <= pcs_pkg::FLASH_LAST
    |=> nvm_write_go == $past(app_region_write_protect))
    else $error("application protect wrong");
endmodule
bind pcs_core pcs_core_sva pcs_core_sva_i (.*);

// ===== dv/pcs_cpu_model.sv
`timescale 1ns/1ps
module pcs_cpu_model
(
  input  wire logic        clk,
  output pcs_pkg::pcs_op_t op,
  output logic [20:0]      target
);
  // Issues one flow request only when asked, never beside a register access
  task automatic issue(input pcs_pkg::pcs_op_t o, input logic [20:0] t);
    @(posedge clk);
    op     <= o;
    target <= t;
    @(posedge clk);
    op     <= pcs_pkg::PCS_OP_NONE;
    target <= ~t;
  endtask
  initial op = pcs_pkg::PCS_OP_NONE;
  initial target = '0;
endmodule

// ===== dv/program_counter_return_stack_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module program_counter_return_stack_tb_top;
  localparam int SB = pcs_pkg::FLASH_LAST - pcs_pkg::SAF_SPAN;
  logic             clk, rstn, por, bb_n, saf_n, wpa, wpb, wps, fse;
  logic             nreq, wr, rd, exok, go, flt;
  logic [3:0]       bsz, addr;
  logic [7:0]       wd, rdata;
  logic [20:0]      nadr, tgt, pc;
  pcs_pkg::pcs_op_t op;
  int               miscompares, tests_run, msp, mpc, lh, lu, err, ovf, unf;
  int               stk[128];
  pcs_cpu_model pcs_cpu_model_i (.clk(clk), .op(op), .target(tgt));
  pcs_core pcs_core_i (.clk(clk), .rstn(rstn), .por(por), .op(op),
    .target(tgt), .boot_partition_enable_n(bb_n),
    .storage_partition_enable_n(saf_n), .boot_partition_size(bsz),
    .app_region_write_protect(wpa), .boot_region_write_protect(wpb),
    .storage_region_write_protect(wps), .stack_fault_reset_enable(fse),
    .nvm_write_req(nreq), .nvm_write_addr(nadr), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .pc(pc),
    .fetch_exec_ok(exok), .nvm_write_go(go), .stack_fault_reset(flt));
  task automatic end_sim();
    $display("Compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic op_do(pcs_pkg::pcs_op_t o, int t);
    int f;
    f = 0;
    pcs_cpu_model_i.issue(o, 21'(t));
    if (o == pcs_pkg::PCS_OP_SEQ) mpc = mpc + 2;
    if (o == pcs_pkg::PCS_OP_JUMP) mpc = t;
    if (o == pcs_pkg::PCS_OP_CALL)
    begin
      f = msp == 127 && fse;
      if (msp == 127) ovf = 1;
      if (msp < 127) msp++;
      if (!f) stk[msp] = (mpc + 2) & 'h1FFFFF;
      mpc = f ? 0 : t;
      if (f) msp = 0;
    end
    if (o == pcs_pkg::PCS_OP_RET)
    begin
      mpc = stk[msp];
      if (mpc == 0) unf = 1;
      f = mpc == 0 && fse;
      msp = f ? 0 : (msp - 1) & 127;
    end
    mpc &= 'h1FFFFE;
    #1;
    `CHK(pc, 21'(mpc))
    `CHK(flt, 1'(f))
  endtask
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    wr   <= 1'b1;
    addr <= a;
    wd   <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (a == 0) mpc = ((lu << 16) | (lh << 8) | d) & 'h1FFFFE;
    if (a == 1) lh = d;
    if (a == 2) lu = d;
    if (a == 3) stk[msp][7:0] = d;
    if (a == 4) stk[msp][15:8] = d;
    if (a == 5) stk[msp][20:16] = d[4:0];
    if (a == 6) msp = d & 127;
    if (a == 7) ovf = d[7];
    if (a == 7) unf = d[6];
    #1;
    `CHK(pc, 21'(mpc))
  endtask
  task automatic rd_reg(logic [3:0] a);
    int e;
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    if (a == 0) {lh, lu} = {(mpc >> 8) & 255, mpc >> 16};
    e = a == 0 ? mpc : a == 1 ? lh : a == 2 ? lu : a == 3 ? stk[msp] :
      a == 4 ? stk[msp] >> 8 : a == 5 ? stk[msp] >> 16 : a == 6 ? msp :
      a == 7 ? ovf * 128 + unf * 64 : a == 8 ? err : 0;
    #1;
    `CHK(rdata, 8'(e))
  endtask
  task automatic nvm(int k);
    int bl, a, ok;
    @(posedge clk);
    bl = (bsz + 1) * 'h200 - 1;
    a = k == 0 ? bl : k == 1 ? bl + 1 : k == 2 ? SB : SB - 1;
    ok = (!bb_n && a <= bl) ? wpb : (!saf_n && a >= SB) ? wps : wpa;
    nreq <= 1'b1;
    nadr <= 21'(a);
    @(posedge clk);
    nreq <= 1'b0;
    #1;
    `CHK(go, 1'(ok))
    if (!ok) err = 1;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  initial
  begin
    {rstn, wr, rd, nreq, addr, wd, nadr, bsz, fse} = '0;
    {por, bb_n, saf_n, wpa, wpb, wps} = '1;
    void'($urandom(9210));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    por  <= 1'b0;
    for (int a = 6; a < 16; a++) rd_reg(4'(a));
    rd_reg(4'h0);
    for (int a = 3; a < 6; a++) wr_reg(4'(a), 8'h00);
    for (int i = 0; i < 40; i++)
    begin
      op_do(pcs_pkg::pcs_op_t'(1 + $urandom % 3), $urandom & 'h1FFFFE);
      rd_reg(4'(3 + i % 4));
    end
    while (msp > 0) op_do(pcs_pkg::PCS_OP_RET, 0);
    wr_reg(4'h1, 8'h34);
    wr_reg(4'h2, 8'h05);
    wr_reg(4'h0, 8'h67);
    op_do(pcs_pkg::PCS_OP_JUMP, 'h1ABCDE);
    for (int a = 0; a < 3; a++) rd_reg(4'(a));
    wr_reg(4'h6, 8'h7E);
    repeat (3) op_do(pcs_pkg::PCS_OP_CALL, 'h00AB12);
    for (int a = 3; a < 8; a++) rd_reg(4'(a));
    wr_reg(4'h7, 8'h80);
    wr_reg(4'h7, 8'h00);
    @(posedge clk);
    fse <= 1'b1;
    wr_reg(4'h6, 8'h7F);
    op_do(pcs_pkg::PCS_OP_CALL, 'h001234);
    rd_reg(4'h6);
    rd_reg(4'h7);
    @(posedge clk);
    fse <= 1'b0;
    wr_reg(4'h6, 8'h01);
    for (int a = 3; a < 6; a++) wr_reg(4'(a), 8'h00);
    op_do(pcs_pkg::PCS_OP_RET, 0);
    rd_reg(4'h7);
    @(posedge clk);
    fse <= 1'b1;
    wr_reg(4'h6, 8'h01);
    op_do(pcs_pkg::PCS_OP_RET, 0);
    rd_reg(4'h6);
    @(posedge clk);
    fse <= 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk);
      {bb_n, saf_n, wpa, wpb, wps} <= 5'($urandom);
      bsz <= 4'($urandom);
      nvm(i % 4);
      rd_reg(4'h8);
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      saf_n <= i[1];
      op_do(pcs_pkg::PCS_OP_JUMP, i[0] ? SB - 1 : SB - 3);
      op_do(pcs_pkg::PCS_OP_NONE, 0);
      `CHK(exok, 1'(!(i[0] && !i[1])))
    end
    end_sim();
  end
endmodule

// ===== hdl/pcs_core.sv
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module pcs_core
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              por,
  // Flow request from the instruction decoder
  input  wire pcs_pkg::pcs_op_t  op,
  input  wire logic [20:0]       target,
  // Configuration bits
  input  wire logic              boot_partition_enable_n,
  input  wire logic              storage_partition_enable_n,
  input  wire logic [3:0]        boot_partition_size,
  input  wire logic              app_region_write_protect,
  input  wire logic              boot_region_write_protect,
  input  wire logic              storage_region_write_protect,
  input  wire logic              stack_fault_reset_enable,
  // Flash write attempt
  input  wire logic              nvm_write_req,
  input  wire logic [20:0]       nvm_write_addr,
  // Register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Outputs
  output logic      [20:0]       pc,
  output logic                   fetch_exec_ok,
  output logic                   nvm_write_go,
  output logic                   stack_fault_reset
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [20:0] stack_mem [pcs_pkg::DEPTH];
  logic [6:0]  stack_pointer_reg;
  logic [7:0]  pc_high_latch;
  logic [7:0]  pc_upper_latch;
  logic        stack_overflow_flag;
  logic        stack_underflow_flag;
  logic        nvm_write_error_flag;
  logic [20:0] pc_seq;

  // ------------------------------------------------------------
  // Partition decode
  // ------------------------------------------------------------
  // Last byte address of the boot region for a given size code.
  // The product is cut to the counter width on purpose: even the
  // largest size code ends far below the top of the flash.
  function automatic logic [20:0] boot_last_of(input logic [3:0] bsz);
    logic [20:0] units;
    units = 21'(bsz) + 21'h000001;
    boot_last_of = 21'(units * pcs_pkg::BOOT_UNIT) - 21'h000001;
  endfunction

  // Storage region is tested first; the boot region cannot reach it,
  // so the order matters for no size code, not even the largest.
  function automatic pcs_pkg::pcs_region_t region_of(
    input logic [20:0] a,
    input logic        bb_n,
    input logic        saf_n,
    input logic [3:0]  bsz
  );
    logic [20:0] storage_base;
    storage_base = pcs_pkg::FLASH_LAST - pcs_pkg::SAF_SPAN;
    if (!saf_n && a >= storage_base && a <= pcs_pkg::FLASH_LAST)
      region_of = pcs_pkg::PCS_SAF;
    else if (!bb_n && a <= boot_last_of(bsz))
      region_of = pcs_pkg::PCS_BOOT;
    else
      region_of = pcs_pkg::PCS_APP;
  endfunction

  // Write permit of a region; a protect input low means protected.
  // An unused region code is treated as protected, the safe side.
  function automatic logic region_writable(
    input pcs_pkg::pcs_region_t r,
    input logic                 app_wp,
    input logic                 boot_wp,
    input logic                 saf_wp
  );
    case (r)
      pcs_pkg::PCS_APP:  region_writable = app_wp;
      pcs_pkg::PCS_BOOT: region_writable = boot_wp;
      pcs_pkg::PCS_SAF:  region_writable = saf_wp;
      default:           region_writable = 1'b0;
    endcase
  endfunction

  wire pcs_pkg::pcs_region_t fetch_region = region_of(pc_seq,
    boot_partition_enable_n, storage_partition_enable_n,
    boot_partition_size);
  wire pcs_pkg::pcs_region_t wr_region = region_of(nvm_write_addr,
    boot_partition_enable_n, storage_partition_enable_n,
    boot_partition_size);
  wire fetch_permit = (fetch_region != pcs_pkg::PCS_SAF);
  wire wr_protected = !region_writable(wr_region,
    app_region_write_protect, boot_region_write_protect,
    storage_region_write_protect);
  wire wr_ok = nvm_write_req && !wr_protected;

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  // One strobe qualifies one address; the master never raises both
  // strobes together, so one shared decode serves reads and writes.
  function automatic logic reg_hit(
    input logic       strobe,
    input logic [3:0] addr,
    input logic [3:0] which
  );
    reg_hit = strobe && (addr == which);
  endfunction

  // ------------------------------------------------------------
  // Stack and counter control
  // ------------------------------------------------------------
  wire is_push   = (op == pcs_pkg::PCS_OP_CALL);
  wire is_pop    = (op == pcs_pkg::PCS_OP_RET);
  wire sp_full   = (stack_pointer_reg == pcs_pkg::SP_MAX);
  wire push_ovf  = is_push && sp_full;
  wire ovf_reset = push_ovf && stack_fault_reset_enable;
  wire [20:0] ret_addr = pc + pcs_pkg::PC_STEP;
  wire [20:0] pop_val  = stack_mem[stack_pointer_reg];
  wire pop_zero  = is_pop && (pop_val == pcs_pkg::PC_RESET);
  wire unf_reset = pop_zero && stack_fault_reset_enable;
  wire [6:0] sp_inc = sp_full ? stack_pointer_reg
                              : stack_pointer_reg + 7'h01;
  wire [6:0] sp_dec = stack_pointer_reg - 7'h01;
  wire wr_pcl  = reg_hit(reg_wr, reg_addr, pcs_pkg::A_PCL);
  wire rd_pcl  = reg_hit(reg_rd, reg_addr, pcs_pkg::A_PCL);
  wire wr_lath = reg_hit(reg_wr, reg_addr, pcs_pkg::A_PC_HIGH_LATCH);
  wire wr_latu = reg_hit(reg_wr, reg_addr, pcs_pkg::A_PC_UPPER_LATCH);
  wire wr_top_of_stack_low = reg_hit(reg_wr, reg_addr, pcs_pkg::A_TOP_OF_STACK_LOW);
  wire wr_top_of_stack_high = reg_hit(reg_wr, reg_addr, pcs_pkg::A_TOP_OF_STACK_HIGH);
  wire wr_top_of_stack_upper = reg_hit(reg_wr, reg_addr, pcs_pkg::A_TOP_OF_STACK_UPPER);
  wire wr_sp   = reg_hit(reg_wr, reg_addr, pcs_pkg::A_STACK_POINTER_REG);
  wire wr_pcon = reg_hit(reg_wr, reg_addr, pcs_pkg::A_POWER_CONTROL_STATUS0);
  wire wr_nerr = reg_hit(reg_wr, reg_addr, pcs_pkg::A_NVMERR);
  wire [20:0] top_of_stack  = stack_mem[stack_pointer_reg];
  wire [20:0] pcl_target = {pc_upper_latch[4:0], pc_high_latch,
                            reg_wdata[7:1], 1'b0};

  // Byte merges for top-of-stack writes; other bytes keep the entry.
  wire [20:0] tos_with_low   = {top_of_stack[20:8], reg_wdata};
  wire [20:0] tos_with_high  = {top_of_stack[20:16], reg_wdata, top_of_stack[7:0]};
  wire [20:0] tos_with_upper = {reg_wdata[4:0], top_of_stack[15:0]};

  always_comb
  begin
    pc_seq = pc + pcs_pkg::PC_STEP;
  end

  // ------------------------------------------------------------
  // Program counter
  // ------------------------------------------------------------
  // A low-byte write beats a flow request in the same cycle unless that request causes a fault reset; the
  // decoder is expected to keep the two apart anyway.
  logic [20:0] next_pc;
  always_comb
  begin
    next_pc = pc;
    if (ovf_reset || unf_reset)
      next_pc = pcs_pkg::PC_RESET;
    else if (wr_pcl)
      next_pc = pcl_target;
    else if (op == pcs_pkg::PCS_OP_SEQ)
      next_pc = pc_seq;
    else if (op == pcs_pkg::PCS_OP_JUMP || is_push)
      next_pc = {target[20:1], 1'b0};
    else if (is_pop)
      next_pc = {pop_val[20:1], 1'b0};
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      pc <= pcs_pkg::PC_RESET;
    else
      pc <= next_pc;
  end

  // Latches change only on software writes or a low-byte read.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      pc_high_latch <= 8'h00;
    else if (rd_pcl)
      pc_high_latch <= pc[15:8];
    else if (wr_lath)
      pc_high_latch <= reg_wdata;
  end

  // The upper latch keeps all eight bits; only five reach the counter.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      pc_upper_latch <= 8'h00;
    else if (rd_pcl)
      pc_upper_latch <= {3'h0, pc[20:16]};
    else if (wr_latu)
      pc_upper_latch <= reg_wdata;
  end

  // ------------------------------------------------------------
  // Stack pointer and storage
  // ------------------------------------------------------------
  // Fault resets win, then flow requests, then a software write, so
  // a push never loses its slot to a pointer write in the same cycle.
  logic [6:0] next_stack_pointer;
  always_comb
  begin
    next_stack_pointer = stack_pointer_reg;
    if (ovf_reset || unf_reset)
      next_stack_pointer = pcs_pkg::SP_RESET;
    else if (is_push)
      next_stack_pointer = sp_inc;
    else if (is_pop)
      next_stack_pointer = sp_dec;
    else if (wr_sp)
      next_stack_pointer = reg_wdata[6:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      stack_pointer_reg <= pcs_pkg::SP_RESET;
    else
      stack_pointer_reg <= next_stack_pointer;
  end

  // Stack contents survive resets, as the array has no reset term.
  always_ff @(posedge clk)
  begin
    if (rstn && is_push && !ovf_reset)
      stack_mem[sp_inc] <= ret_addr;
    else if (rstn && wr_top_of_stack_low)
      stack_mem[stack_pointer_reg] <= tos_with_low;
    else if (rstn && wr_top_of_stack_high)
      stack_mem[stack_pointer_reg] <= tos_with_high;
    else if (rstn && wr_top_of_stack_upper)
      stack_mem[stack_pointer_reg] <= tos_with_upper;
  end

  // ------------------------------------------------------------
  // Flags: hardware set wins over software clear
  // ------------------------------------------------------------
  // Power-on and software writes clear the flags, the ordinary reset does not, so software can still see why a
  // fault reset happened after the ordinary reset has passed.
  always_ff @(posedge clk)
  begin
    if (por)
      stack_overflow_flag <= 1'b0;
    else if (push_ovf)
      stack_overflow_flag <= 1'b1;
    else if (wr_pcon)
      stack_overflow_flag <= reg_wdata[pcs_pkg::B_OVF];
  end

  always_ff @(posedge clk)
  begin
    if (por)
      stack_underflow_flag <= 1'b0;
    else if (pop_zero)
      stack_underflow_flag <= 1'b1;
    else if (wr_pcon)
      stack_underflow_flag <= reg_wdata[pcs_pkg::B_UNF];
  end

  always_ff @(posedge clk)
  begin
    if (por)
      nvm_write_error_flag <= 1'b0;
    else if (nvm_write_req && wr_protected)
      nvm_write_error_flag <= 1'b1;
    else if (wr_nerr)
      nvm_write_error_flag <= reg_wdata[0];
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  // The permit looks one fetch ahead, so it stands when the decoder
  // is about to fetch from the next word.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      fetch_exec_ok <= 1'b1;
    else
      fetch_exec_ok <= fetch_permit;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      nvm_write_go <= 1'b0;
    else
      nvm_write_go <= wr_ok;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      stack_fault_reset <= 1'b0;
    else
      stack_fault_reset <= ovf_reset || unf_reset;
  end

  logic [7:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      pcs_pkg::A_PCL:    rd_mux = pc[7:0];
      pcs_pkg::A_PC_HIGH_LATCH: rd_mux = pc_high_latch;
      pcs_pkg::A_PC_UPPER_LATCH: rd_mux = pc_upper_latch;
      pcs_pkg::A_TOP_OF_STACK_LOW:   rd_mux = top_of_stack[7:0];
      pcs_pkg::A_TOP_OF_STACK_HIGH:   rd_mux = top_of_stack[15:8];
      pcs_pkg::A_TOP_OF_STACK_UPPER:   rd_mux = {3'h0, top_of_stack[20:16]};
      pcs_pkg::A_STACK_POINTER_REG: rd_mux = {1'b0, stack_pointer_reg};
      pcs_pkg::A_POWER_CONTROL_STATUS0:  rd_mux = {stack_overflow_flag,
                                   stack_underflow_flag, 6'h00};
      pcs_pkg::A_NVMERR: rd_mux = {7'h00, nvm_write_error_flag};
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end
endmodule

// ===== shared/pcs_pkg.sv
package pcs_pkg;
  localparam int PC_W    = 21;
  localparam int SP_W    = 7;
  localparam int DEPTH   = 128;
  localparam logic [6:0]  SP_MAX    = 7'h7F;
  localparam logic [6:0]  SP_RESET  = 7'h00;
  localparam logic [20:0] PC_RESET  = 21'h000000;
  localparam logic [20:0] PC_STEP   = 21'h000002;
  localparam logic [20:0] FLASH_LAST = 21'h00FFFF;
  localparam logic [20:0] SAF_SPAN  = 21'h0000FE;
  localparam logic [20:0] BOOT_UNIT = 21'h000200;
  // Register addresses (4-bit space)
  localparam logic [3:0] A_PCL    = 4'h0;
  localparam logic [3:0] A_PC_HIGH_LATCH = 4'h1;
  localparam logic [3:0] A_PC_UPPER_LATCH = 4'h2;
  localparam logic [3:0] A_TOP_OF_STACK_LOW   = 4'h3;
  localparam logic [3:0] A_TOP_OF_STACK_HIGH   = 4'h4;
  localparam logic [3:0] A_TOP_OF_STACK_UPPER   = 4'h5;
  localparam logic [3:0] A_STACK_POINTER_REG = 4'h6;
  localparam logic [3:0] A_POWER_CONTROL_STATUS0  = 4'h7;
  localparam logic [3:0] A_NVMERR = 4'h8;
  localparam int B_OVF = 7;
  localparam int B_UNF = 6;
  typedef enum logic [1:0] {PCS_APP, PCS_BOOT, PCS_SAF} pcs_region_t;
  typedef enum logic [2:0] {
    PCS_OP_NONE, PCS_OP_SEQ, PCS_OP_JUMP, PCS_OP_CALL, PCS_OP_RET
  } pcs_op_t;
endpackage
